// ---- shared/ccs_pkg.sv ----
// Package with constants and types for the card coupler host select and interrupt block
// Behaviour
// - Signal an event to the host by pulling the interrupt line low.
// - Clear card interrupt on select rising, or power request rising while selected.
// - Status reads high with card present, low with no card.
// - Status reads high with supply healthy, low when supply is overloaded.
// - A pending interrupt line changes no other internal behaviour.
// - Card supply health is monitored continuously and shown in status.
// - Battery over or undervoltage shuts the card down and updates status.
// - While selected, host pins are sampled and act on the device.
// - While deselected, host pins are ignored.
// - While deselected, card data and reset hold levels, clock keeps programmed state.
// - Card supply and clock keep working while deselected.
// - Power request falling while deselected leaves the supply on.
// - In minimum power only card detection and battery monitoring stay active; supply overload and select are still sampled too.
// - Minimum power ends at once on card insertion or select low.
// - Card clock keeps fifty percent duty for every divider ratio, 1:1 included.
package ccs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

  // ==========================================================
  // Field positions of the control register
  localparam int CTRL_CLK_RUN = 0;
  localparam int CTRL_STOP_LVL = 1;
  localparam int CTRL_DIV_LSB = 2;
  localparam int CTRL_MINPWR = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Interrupt event bit positions
  localparam int EV_CARD = 0;
  localparam int EV_SUPPLY = 1;
  localparam int EV_BATT = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Count of pins brought through synchronisers
  localparam int PIN_W = 8;
  localparam int DIV_W = 3;
  // Synchroniser reset levels; select idles high so release of reset makes no false select edge
  localparam logic [PIN_W-1:0] PIN_RESET = 8'h01;

  // ==========================================================
  // Pins coming from outside the clock domain
  typedef struct packed {
    logic refClk;
    logic batteryFault;
    logic supplyOverload;
    logic cardDetect;
    logic hostReset;
    logic hostIo;
    logic cardPowerRequest;
    logic unitSelectN;
  } ccs_pins_t;

  // Control register contents
  typedef struct packed {
    logic minPowerReq;
    logic [DIV_W-1:0] divSel;
    logic stopLevel;
    logic clkRun;
  } ccs_ctrl_t;

  // Operating state
  typedef enum logic {ST_ACTIVE, ST_MINPWR} ccs_state_t;

endpackage

// ---- core/ccs_host_select_irq.sv ----
// Card coupler host select, interrupt, status and card clock logic with an AHB-Lite register slave
`timescale 1ns/100ps
module ccs_host_select_irq
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  // Pins from host and card side
  input wire ccs_pkg::ccs_pins_t pinsIn,
  // Pins to host
  output logic intN,
  output logic statusOut,
  // Pins to card
  output logic cardSupplyEn,
  output logic cardClockOut,
  output logic cardResetLine,
  output logic cardIoLine,
  output logic cardIoOe
);
  import ccs_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic [PIN_W-1:0] sync3_ff;
  ccs_pins_t pinS;
  ccs_pins_t pinD;

  // Two flops per pin, third only feeds edge detection
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          sync1_ff[gi] <= PIN_RESET[gi];
          sync2_ff[gi] <= PIN_RESET[gi];
          sync3_ff[gi] <= PIN_RESET[gi];
        end
        else if (clkEn)
        begin
          sync1_ff[gi] <= pinsIn[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  assign pinS = ccs_pins_t'(sync2_ff);
  assign pinD = ccs_pins_t'(sync3_ff);

  // ==========================================================
  // Decoded pin events
  logic selected;
  logic selRise;
  logic pwrRise;
  logic pwrFall;
  logic cardChange;
  logic cardInsert;
  logic cardClear;

  assign selected = !pinS.unitSelectN;
  assign selRise = pinS.unitSelectN && !pinD.unitSelectN;
  // Host pins count only while selected
  assign pwrRise = selected && pinS.cardPowerRequest && !pinD.cardPowerRequest;
  assign pwrFall = selected && !pinS.cardPowerRequest && pinD.cardPowerRequest;
  assign cardChange = pinS.cardDetect != pinD.cardDetect;
  assign cardInsert = pinS.cardDetect && !pinD.cardDetect;
  assign cardClear = selRise || pwrRise;

  // ==========================================================
  // Registers and state
  ccs_ctrl_t ctrl_ff;
  logic [EV_W-1:0] irqStat_ff;
  logic [EV_W-1:0] irqMask_ff;
  ccs_state_t state_ff;
  ccs_state_t nxt_state;
  logic supplyOn_ff;
  logic intPend_ff;
  logic statusOut_ff;
  logic supplyFaultD_ff;
  logic battFaultD_ff;
  logic [EV_W-1:0] events;
  logic minPower;

  assign minPower = state_ff == ST_MINPWR;

  // Card supply follows host requests; battery fault forces shutdown
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      supplyOn_ff <= 1'b0;
    else if (clkEn)
    begin
      if (pinS.batteryFault)
        supplyOn_ff <= 1'b0;
      else if (pwrRise)
        supplyOn_ff <= 1'b1;
      else if (pwrFall)
        supplyOn_ff <= 1'b0; // Deselected fall never gets here
    end
  end

  // Host interrupt line: set on card change, held until a clear
  // Only the status pin reads the pending flag; supply, clock and card lines ignore it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      intPend_ff <= 1'b0;
    else if (clkEn)
    begin
      if (cardChange)
        intPend_ff <= 1'b1; // New event wins over a clear
      else if (cardClear)
        intPend_ff <= 1'b0;
    end
  end

  // Status pin shows card presence while a card event is pending, else health
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      statusOut_ff <= 1'b0;
    else if (clkEn)
    begin
      if (intPend_ff || cardChange)
        statusOut_ff <= pinS.cardDetect;
      else
        statusOut_ff <= !pinS.supplyOverload && !pinS.batteryFault;
    end
  end

  // Minimum power state: entered on request with supply off and deselected
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ACTIVE:
        if (ctrl_ff.minPowerReq && !supplyOn_ff && !selected)
          nxt_state = ST_MINPWR;
      ST_MINPWR:
        if (cardInsert || selected)
          nxt_state = ST_ACTIVE;
      default:
        nxt_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_ff <= ST_ACTIVE;
    else if (clkEn)
      state_ff <= nxt_state;
  end

  // ==========================================================
  // Card data and reset: follow host while selected, hold otherwise
  logic cardIo_ff;
  logic cardRst_ff;
  logic cardIoOe_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cardIo_ff <= 1'b1;
      cardRst_ff <= 1'b0;
      cardIoOe_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (selected && !minPower)
      begin
        cardIo_ff <= pinS.hostIo;
        cardRst_ff <= pinS.hostReset;
      end
      cardIoOe_ff <= supplyOn_ff; // Held levels persist when deselected
    end
  end

  // ==========================================================
  // Card clock: counts both reference edges, toggles every divSel+1 of them
  logic [DIV_W-1:0] divCnt_ff;
  logic cardClk_ff;
  logic refEdge;
  logic clkActive;

  assign refEdge = pinS.refClk != pinD.refClk;
  // Clock runs as programmed, selected or not, while the card supply is on, but stops in minimum power
  assign clkActive = ctrl_ff.clkRun && supplyOn_ff && !minPower;

  // Toggle spacing is equal for both halves, so duty stays even
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      divCnt_ff <= '0;
      cardClk_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!clkActive)
      begin
        divCnt_ff <= '0;
        cardClk_ff <= ctrl_ff.stopLevel;
      end
      else if (refEdge)
      begin
        if (divCnt_ff >= ctrl_ff.divSel)
        begin
          divCnt_ff <= '0;
          cardClk_ff <= !cardClk_ff;
        end
        else
          divCnt_ff <= divCnt_ff + 3'h1;
      end
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic wrPend_ff;
  logic [7:0] wrAddr_ff;
  logic [31:0] hrdata_ff;
  logic accept;
  logic rdStat;

  assign accept = hsel && htrans[1] && hready;
  assign rdStat = accept && !hwrite && haddr == IRQ_STAT_OFS;

  // Hardware events; battery and supply only on their rising fault
  always_comb
  begin
    events = '0;
    events[EV_CARD] = cardChange;
    events[EV_SUPPLY] = pinS.supplyOverload && !supplyFaultD_ff;
    events[EV_BATT] = pinS.batteryFault && !battFaultD_ff;
  end

  // Address phase latch for writes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
    end
    else if (clkEn)
    begin
      wrPend_ff <= accept && hwrite;
      wrAddr_ff <= haddr;
    end
  end

  // Control and mask writes; minimum power request drops on wake-up
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_ff <= ccs_ctrl_t'(CTRL_RESET[5:0]);
      irqMask_ff <= IRQ_MASK_RESET;
    end
    else if (clkEn)
    begin
      if (wrPend_ff && wrAddr_ff == CTRL_OFS)
        ctrl_ff <= ccs_ctrl_t'(hwdata[5:0]);
      else if (minPower && nxt_state == ST_ACTIVE)
        ctrl_ff.minPowerReq <= 1'b0;
      if (wrPend_ff && wrAddr_ff == IRQ_MASK_OFS)
        irqMask_ff <= hwdata[EV_W-1:0];
    end
  end

  // Sticky status, cleared by read; a same-cycle event stays set
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irqStat_ff <= '0;
      supplyFaultD_ff <= 1'b0;
      battFaultD_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      irqStat_ff <= (rdStat ? '0 : irqStat_ff) | events;
      supplyFaultD_ff <= pinS.supplyOverload;
      battFaultD_ff <= pinS.batteryFault;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      hrdata_ff <= 32'h0000_0000;
    else if (clkEn)
    begin
      hrdata_ff <= 32'h0000_0000;
      if (accept && !hwrite)
        case (haddr)
          CTRL_OFS: hrdata_ff <= {26'h0, ctrl_ff};
          STAT_OFS: hrdata_ff <= {26'h0, selected, minPower, supplyOn_ff, !pinS.batteryFault,
                                  !pinS.supplyOverload, pinS.cardDetect};
          IRQ_STAT_OFS: hrdata_ff <= {29'h0, irqStat_ff};
          IRQ_MASK_OFS: hrdata_ff <= {29'h0, irqMask_ff};
          default: hrdata_ff <= 32'h0000_0000;
        endcase
    end
  end

  // Bus-side interrupt level
  logic irq_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_ff <= 1'b0;
    else if (clkEn)
      irq_ff <= |(irqStat_ff & irqMask_ff);
  end

  // ==========================================================
  // Outputs straight from flops; ready and response tied to constants
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_ff;
  assign intN = !intPend_ff;
  assign statusOut = statusOut_ff;
  assign cardSupplyEn = supplyOn_ff;
  assign cardClockOut = cardClk_ff;
  assign cardResetLine = cardRst_ff;
  assign cardIoLine = cardIo_ff;
  assign cardIoOe = cardIoOe_ff;

  // ==========================================================
  // Assertions
  sequence s_cardEvt;
    clkEn && cardChange;
  endsequence

  sequence s_intLow;
    !intN;
  endsequence

  property p_intSet;
    @(posedge clk) disable iff (!reset_n) s_cardEvt |=> s_intLow;
  endproperty
  a_intSet: assert property (p_intSet) else $error("interrupt not raised");

  property p_intClr;
    @(posedge clk) disable iff (!reset_n) clkEn && cardClear && !cardChange |=> intN;
  endproperty
  a_intClr: assert property (p_intClr) else $error("interrupt not cleared");

  property p_intHold;
    @(posedge clk) disable iff (!reset_n) s_intLow ##0 !(clkEn && cardClear) |=> s_intLow;
  endproperty
  a_intHold: assert property (p_intHold) else $error("interrupt released early");

  property p_statusCard;
    @(posedge clk) disable iff (!reset_n) clkEn && intPend_ff |=> statusOut == $past(pinS.cardDetect);
  endproperty
  a_statusCard: assert property (p_statusCard) else $error("status not card presence");

  property p_statusHealth;
    @(posedge clk) disable iff (!reset_n)
      clkEn && !intPend_ff && !cardChange && pinS.supplyOverload |=> !statusOut;
  endproperty
  a_statusHealth: assert property (p_statusHealth) else $error("overload not shown");

  property p_battOff;
    @(posedge clk) disable iff (!reset_n) clkEn && pinS.batteryFault |=> !cardSupplyEn;
  endproperty
  a_battOff: assert property (p_battOff) else $error("supply on in battery fault");

  property p_deselHold;
    @(posedge clk) disable iff (!reset_n)
      !selected && reset_n |=> $stable(cardIoLine) && $stable(cardResetLine);
  endproperty
  a_deselHold: assert property (p_deselHold) else $error("card lines moved while deselected");

  property p_deselSupply;
    @(posedge clk) disable iff (!reset_n)
      pinS.unitSelectN && !pinS.batteryFault && cardSupplyEn |=> cardSupplyEn;
  endproperty
  a_deselSupply: assert property (p_deselSupply) else $error("supply off while deselected");

  property p_minPwr;
    @(posedge clk) disable iff (!reset_n)
      clkEn && minPower |-> !cardSupplyEn ##1 cardClockOut == $past(ctrl_ff.stopLevel);
  endproperty
  a_minPwr: assert property (p_minPwr) else $error("supply on in minimum power");

  property p_wake;
    @(posedge clk) disable iff (!reset_n) clkEn && minPower && selected |=> !minPower;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");

endmodule // ccs_host_select_irq

// ---- verif/ccs_host_model.sv ----
// Host microcontroller model driving one coupler's pins on a shared bus
`timescale 1ns/100ps
module ccs_host_model
(
  // Clock
  input wire logic clk,
  // Host and card side intent
  input wire logic selReq,
  input wire logic pwrReq,
  input wire logic ioReq,
  input wire logic rstReq,
  input wire logic lowPwr,
  input wire logic cardIn,
  input wire logic overload,
  input wire logic battFault,
  // Pins to the coupler
  output ccs_pkg::ccs_pins_t pins
);
  import ccs_pkg::*;

  logic [2:0] refCnt_ff = 3'h0;
  logic busPat_ff = 1'b0;

  // ====================
  // Reference clock, one toggle every four system clocks, well below the sampling limit
  always_ff @(posedge clk)
  begin
    refCnt_ff <= refCnt_ff + 3'h1;
  end

  // Other couplers keep the shared data lines busy, so a deselected port must not follow them
  always_ff @(posedge clk)
  begin
    busPat_ff <= ~busPat_ff;
  end

  // ====================
  // Pin drive; this coupler has a select line of its own
  always_comb
  begin
    pins.refClk = refCnt_ff[2];
    pins.batteryFault = battFault;
    pins.supplyOverload = overload;
    pins.cardDetect = cardIn;
    pins.unitSelectN = ~selReq | lowPwr; // Held high for minimum power
    pins.cardPowerRequest = pwrReq & ~lowPwr;
    pins.hostIo = lowPwr | (selReq ? ioReq : busPat_ff);
    pins.hostReset = selReq ? rstReq : ~busPat_ff;
  end
endmodule // ccs_host_model

// ---- verif/ccs_host_select_irq_tb_top.sv ----
// Self-checking bench for the card coupler host select and interrupt block
`timescale 1ns/100ps
module ccs_host_select_irq_tb_top;
  import ccs_pkg::*;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic clkEn = 1'b1;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, intN, statusOut;
  logic cardSupplyEn, cardClockOut, cardResetLine, cardIoLine, cardIoOe;
  logic selReq = 1'b0, pwrReq = 1'b0, ioReq = 1'b1, rstReq = 1'b0, lowPwr = 1'b0;
  logic cardIn = 1'b0, overload = 1'b0, battFault = 1'b0;
  ccs_pins_t pinsIn;
  int error_cnt = 0;
  int samples_checked = 0;
  int hi, tg;

  // 25 MHz system clock
  always #20 clk = ~clk;

  ccs_host_model HOST (.clk(clk), .selReq(selReq), .pwrReq(pwrReq), .ioReq(ioReq), .rstReq(rstReq),
    .lowPwr(lowPwr), .cardIn(cardIn), .overload(overload), .battFault(battFault), .pins(pinsIn));

  ccs_host_select_irq DUT (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pinsIn(pinsIn), .intN(intN), .statusOut(statusOut),
    .cardSupplyEn(cardSupplyEn), .cardClockOut(cardClockOut), .cardResetLine(cardResetLine),
    .cardIoLine(cardIoLine), .cardIoOe(cardIoOe));

  // ====================
  // Verdict, counts and comparisons
  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic got, input logic exp);
    chkReg({31'h0, got}, {31'h0, exp});
  endtask

  task automatic done(input string s);
    $display("Test %s finished, %0d mismatches so far", s, error_cnt);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ====================
  // Bus master; a wait that never sees ready ends the run
  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitReady();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chkReg(rd, e);
    chkPin(hresp, 1'b0);
  endtask

  // Counts high samples and toggles of the card clock
  task automatic measure(input int n);
    logic p;
    hi = 0;
    tg = 0;
    p = cardClockOut;
    repeat (n)
    begin
      @(posedge clk);
      hi += (cardClockOut === 1'b1);
      tg += (cardClockOut !== p);
      p = cardClockOut;
    end
  endtask

  // ====================
  // Main sequence
  initial
  begin
    tick(3);
    reset_n <= 1'b1;
    tick(5);
    chkPin(intN, 1'b1);
    chkPin(statusOut, 1'b1);
    chkPin(cardSupplyEn, 1'b0);
    chkPin(irq, 1'b0);
    rdChk(CTRL_OFS, CTRL_RESET);
    rdChk(IRQ_MASK_OFS, {29'h0, IRQ_MASK_RESET});
    wr(8'h10, 32'hFFFF_FFFF);
    rdChk(8'h10, 32'h0);
    done("reset");
    // Insertion, removal and both ways of clearing the host interrupt
    cardIn <= 1'b1;
    tick(5);
    chkPin(intN, 1'b0);
    chkPin(statusOut, 1'b1);
    tick(20);
    chkPin(intN, 1'b0);
    selReq <= 1'b1;
    tick(5);
    chkPin(intN, 1'b0);
    selReq <= 1'b0;
    tick(5);
    chkPin(intN, 1'b1);
    wr(IRQ_MASK_OFS, 32'h1);
    cardIn <= 1'b0;
    tick(5);
    chkPin(intN, 1'b0);
    chkPin(statusOut, 1'b0);
    chkPin(irq, 1'b1);
    rdChk(IRQ_STAT_OFS, 32'h1);
    tick(3);
    chkPin(irq, 1'b0);
    selReq <= 1'b1;
    tick(5);
    pwrReq <= 1'b1;
    tick(5);
    chkPin(intN, 1'b1);
    chkPin(cardSupplyEn, 1'b1);
    chkPin(cardIoOe, 1'b1);
    done("interrupt");
    // Card lines follow while selected, hold while the bus carries other traffic
    ioReq <= 1'b0;
    rstReq <= 1'b1;
    tick(5);
    chkPin(cardIoLine, 1'b0);
    chkPin(cardResetLine, 1'b1);
    selReq <= 1'b0;
    tick(2);
    pwrReq <= 1'b0;
    tick(20);
    chkPin(cardIoLine, 1'b0);
    chkPin(cardResetLine, 1'b1);
    chkPin(cardSupplyEn, 1'b1);
    done("deselect");
    // Card clock duty for divider settings 0 to 3 while deselected and an interrupt is pending
    cardIn <= 1'b1;
    tick(5);
    chkPin(intN, 1'b0);
    for (int d = 0; d < 4; d++)
    begin
      wr(CTRL_OFS, 32'h1 | (32'(d) << CTRL_DIV_LSB));
      tick(80);
      measure(192);
      chkReg(32'(hi), 32'h60);
      chkReg(32'(tg), 32'(48 / (d + 1)));
    end
    // Stopped clock parks at the programmed high level
    wr(CTRL_OFS, 32'h2);
    tick(3);
    chkPin(cardClockOut, 1'b1);
    selReq <= 1'b1;
    tick(5);
    selReq <= 1'b0;
    tick(5);
    chkPin(intN, 1'b1);
    done("clock");
    // Supply overload on the status pin and in the event bits
    overload <= 1'b1;
    tick(5);
    chkPin(statusOut, 1'b0);
    wr(IRQ_MASK_OFS, 32'h7);
    tick(2);
    chkPin(irq, 1'b1);
    rdChk(IRQ_STAT_OFS, 32'h3);
    tick(3);
    chkPin(irq, 1'b0);
    overload <= 1'b0;
    tick(5);
    chkPin(statusOut, 1'b1);
    done("overload");
    // Battery fault drops the card supply, but only once the enable lets state move
    clkEn <= 1'b0;
    battFault <= 1'b1;
    tick(5);
    chkPin(cardSupplyEn, 1'b1);
    clkEn <= 1'b1;
    tick(5);
    chkPin(cardSupplyEn, 1'b0);
    chkPin(statusOut, 1'b0);
    rdChk(IRQ_STAT_OFS, 32'h4);
    battFault <= 1'b0;
    tick(5);
    done("battery");
    // Minimum power, quiet card clock, exit by insertion and by select
    cardIn <= 1'b0;
    lowPwr <= 1'b1;
    wr(CTRL_OFS, 32'h21);
    tick(5);
    rdChk(STAT_OFS, 32'h16);
    measure(40);
    chkReg(32'(tg), 32'h0);
    cardIn <= 1'b1;
    tick(5);
    rdChk(STAT_OFS, 32'h07);
    wr(CTRL_OFS, 32'h21);
    tick(5);
    rdChk(STAT_OFS, 32'h17);
    lowPwr <= 1'b0;
    selReq <= 1'b1;
    tick(5);
    rdChk(STAT_OFS, 32'h27);
    done("minimum power");
    print_verdict();
  end
endmodule // ccs_host_select_irq_tb_top
